// ===== logic/rdc_bank.sv
/*
 * Configuration bank for log-amp shaping, receive gain, burst pin monitor
 * and drive supply regulator, with the stuck-pulse monitor on the burst pins.
 * Assumes the frame decoder runs on clock_in; burst pins are asynchronous.
 */
`timescale 1ns/1ps
module rdc_bank
    import rdc_pkg::*;
#(
    parameter int unsigned WIN0_CYC = RDC_WIN0_US * RDC_CLK_MHZ,
    parameter int unsigned WIN1_CYC = RDC_WIN1_US * RDC_CLK_MHZ,
    parameter int unsigned WIN2_CYC = RDC_WIN2_US * RDC_CLK_MHZ,
    parameter int unsigned WIN3_CYC = RDC_WIN3_US * RDC_CLK_MHZ
) (
    // Clock and reset
    input  wire logic            clock_in,
    input  wire logic            rstn_in,
    // Register port
    input  wire logic            reg_wr_in,
    input  wire logic            reg_rd_in,
    input  wire logic [5:0]      reg_addr_in,
    input  wire logic [7:0]      reg_wdata_in,
    output logic      [7:0]      reg_rdata_out,
    // Factory trims and device state
    input  wire logic [2:0]      factory_slope_in,
    input  wire logic [3:0]      factory_intercept_in,
    input  wire logic            burst_active_in,
    input  wire logic            manual_charge_request_in,
    // Burst control pins
    input  wire logic            burst_pin_a_in,
    input  wire logic            burst_pin_b_in,
    // Analog and supply controls, stuck-pulse fault flag
    output rdc_analog_cfg_t      analog_cfg_out,
    output rdc_supply_cfg_t      supply_cfg_out,
    output logic                 stuck_pulse_fault_out
);
    logic [7:0]           shaping;
    logic [7:0]           gain;
    logic [7:0]           monitor;
    logic [7:0]           supply;
    logic                 fault;
    logic                 charge_on;
    logic                 burst_d;
    logic                 manual_d;
    logic [1:0]           pin_s1;
    logic [1:0]           pin_s2;
    logic [1:0]           pin_d;
    logic [RDC_CNT_W-1:0] cnt [2];
    logic [1:0]           stuck;
    logic [RDC_CNT_W-1:0] win;
    logic                 check_en;
    logic                 both_high;
    logic                 status_rd;
    logic [7:0]           next_rdata;

    function automatic logic [RDC_CNT_W-1:0] win_cycles(
        input logic [2:0] code
    );
        case (code)
            3'h0:    win_cycles = RDC_CNT_W'(WIN0_CYC);
            3'h1:    win_cycles = RDC_CNT_W'(WIN1_CYC);
            3'h2:    win_cycles = RDC_CNT_W'(WIN2_CYC);
            3'h3:    win_cycles = RDC_CNT_W'(WIN3_CYC);
            3'h4:    win_cycles = RDC_CNT_W'(RDC_WIN4_CYC);
            3'h5:    win_cycles = RDC_CNT_W'(RDC_WIN5_CYC);
            3'h6:    win_cycles = RDC_CNT_W'(RDC_WIN6_CYC);
            default: win_cycles = '1;
        endcase
    endfunction

    function automatic logic hit(input logic [5:0] ofs);
        hit = reg_wr_in && (reg_addr_in == ofs);
    endfunction

    // Register writes, masked to the writable bits
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            shaping <= RDC_RST_SHAPING;
            gain    <= RDC_RST_GAIN;
            monitor <= RDC_RST_MONITOR;
            supply  <= RDC_RST_SUPPLY;
        end else begin
            if (hit(RDC_OFS_SHAPING)) begin
                shaping <= reg_wdata_in & RDC_MASK_SHAPING;
            end
            if (hit(RDC_OFS_GAIN)) begin
                gain <= reg_wdata_in & RDC_MASK_GAIN;
            end
            if (hit(RDC_OFS_MONITOR)) begin
                monitor <= reg_wdata_in & RDC_MASK_MONITOR;
            end
            if (hit(RDC_OFS_SUPPLY)) begin
                supply <= reg_wdata_in & RDC_MASK_SUPPLY;
            end
        end
    end

    // Read data mux
    always_comb begin
        next_rdata = 8'h00;
        case (reg_addr_in)
            RDC_OFS_SHAPING: next_rdata = shaping;
            RDC_OFS_GAIN:    next_rdata = gain;
            RDC_OFS_MONITOR: next_rdata = monitor;
            RDC_OFS_SUPPLY:  next_rdata = supply;
            RDC_OFS_STATUS:  next_rdata[RDC_BIT_STAT_FAULT] = fault;
            default:         next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            reg_rdata_out <= next_rdata;
        end
    end

    // Analog controls
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            analog_cfg_out <= '0;
        end else begin
            analog_cfg_out.first_stage_off <= gain[RDC_BIT_FIRST_OFF];
            analog_cfg_out.last_stage_off  <= gain[RDC_BIT_LAST_OFF];
            analog_cfg_out.span_5v         <= gain[RDC_BIT_SPAN];
            analog_cfg_out.preamp_gain_select <= gain[1:0];
            if (shaping[RDC_BIT_OVERRIDE]) begin
                analog_cfg_out.log_slope_trim     <= shaping[6:4];
                analog_cfg_out.log_intercept_trim <= shaping[3:0];
            end else begin
                analog_cfg_out.log_slope_trim     <= factory_slope_in;
                analog_cfg_out.log_intercept_trim <= factory_intercept_in;
            end
        end
    end

    // Burst pin synchronisers
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            pin_s1 <= 2'h0;
            pin_s2 <= 2'h0;
            pin_d  <= 2'h0;
        end else begin
            pin_s1 <= {burst_pin_b_in, burst_pin_a_in};
            pin_s2 <= pin_s1;
            pin_d  <= pin_s2;
        end
    end

    assign win       = win_cycles(monitor[4:2]);
    assign check_en  = (monitor[4:2] != RDC_WIN_OFF)
                    && (monitor[1:0] != RDC_SCHEME_NONE)
                    && burst_active_in;
    assign both_high = (monitor[1:0] == RDC_SCHEME_DUAL) && (&pin_s2);

    // Stuck-pulse timers, one per pin
    for (genvar i = 0; i < 2; i++) begin : g_pin
        logic watch;
        assign watch = (i == 1) || (monitor[1:0] == RDC_SCHEME_DUAL);
        always_ff @(posedge clock_in) begin
            if (!rstn_in) begin
                cnt[i] <= '0;
            end else if (!check_en || !watch || both_high
                         || (pin_s2[i] != pin_d[i])) begin
                cnt[i] <= '0;
            end else if (cnt[i] != '1) begin
                cnt[i] <= cnt[i] + RDC_CNT_W'(1);
            end
        end
        assign stuck[i] = watch && check_en && (cnt[i] > win);
    end

    // Fault flag: set wins over clear-on-read of status
    assign status_rd = reg_rd_in && (reg_addr_in == RDC_OFS_STATUS);
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            fault <= 1'b0;
        end else if (|stuck) begin
            fault <= 1'b1;
        end else if (status_rd) begin
            fault <= 1'b0;
        end
    end
    assign stuck_pulse_fault_out = fault;

    // Drive supply charging control
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            burst_d  <= 1'b0;
            manual_d <= 1'b0;
        end else begin
            burst_d  <= burst_active_in;
            manual_d <= manual_charge_request_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            charge_on <= 1'b0;
        end else if (supply[RDC_BIT_FLOAT]) begin
            charge_on <= 1'b0;
        end else if (!supply[RDC_BIT_AUTO_STOP]) begin
            charge_on <= 1'b1;
        end else if (manual_charge_request_in) begin
            charge_on <= 1'b1;
        end else if (manual_d || (burst_d && !burst_active_in)) begin
            charge_on <= 1'b0;
        end else if (burst_active_in) begin
            charge_on <= 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            supply_cfg_out <= '0;
        end else begin
            supply_cfg_out.charge_enable <= charge_on;
            supply_cfg_out.supply_float  <= supply[RDC_BIT_FLOAT];
            supply_cfg_out.charge_current_select <=
                supply[RDC_BIT_CURRENT];
            supply_cfg_out.charge_voltage_select <= supply[3:0];
        end
    end

    property p_reset_values;
        @(posedge clock_in) $rose(rstn_in) |->
            supply == RDC_RST_SUPPLY && shaping == 8'h00 && gain == 8'h00;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("reset values wrong");

    property p_override;
        @(posedge clock_in) disable iff (!rstn_in)
        shaping[RDC_BIT_OVERRIDE] && $stable(shaping) |=>
            analog_cfg_out.log_slope_trim == $past(shaping[6:4]);
    endproperty
    a_override: assert property (p_override)
        else $error("slope trim not applied");

    property p_reserved;
        @(posedge clock_in) disable iff (!rstn_in)
        gain[5:3] == 3'h0 && monitor[7:5] == 3'h0 && !supply[7];
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bit set");

    property p_write_span;
        @(posedge clock_in) disable iff (!rstn_in)
        reg_wr_in && reg_addr_in == RDC_OFS_GAIN |=> ##1
            analog_cfg_out.span_5v == $past(reg_wdata_in[RDC_BIT_SPAN], 2);
    endproperty
    a_write_span: assert property (p_write_span)
        else $error("span select not passed out");

    property p_fault_set;
        @(posedge clock_in) disable iff (!rstn_in)
        |stuck |=> stuck_pulse_fault_out;
    endproperty
    a_fault_set: assert property (p_fault_set)
        else $error("fault not raised");

    property p_disabled;
        @(posedge clock_in) disable iff (!rstn_in)
        monitor[4:2] == RDC_WIN_OFF |=> !$rose(stuck_pulse_fault_out);
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("check ran while disabled");

    property p_both_high;
        @(posedge clock_in) disable iff (!rstn_in)
        both_high |=> cnt[0] == '0 && cnt[1] == '0;
    endproperty
    a_both_high: assert property (p_both_high)
        else $error("timer ran with both pins high");

    property p_float;
        @(posedge clock_in) disable iff (!rstn_in)
        supply[RDC_BIT_FLOAT] |=> ##1 !supply_cfg_out.charge_enable;
    endproperty
    a_float: assert property (p_float)
        else $error("charging while floating");

    property p_auto_stop;
        @(posedge clock_in) disable iff (!rstn_in)
        supply[RDC_BIT_AUTO_STOP] && !supply[RDC_BIT_FLOAT]
            && !manual_charge_request_in && burst_d && !burst_active_in
            |=> !charge_on;
    endproperty
    a_auto_stop: assert property (p_auto_stop)
        else $error("charging not stopped after burst");

    property p_manual;
        @(posedge clock_in) disable iff (!rstn_in)
        !supply[RDC_BIT_FLOAT] && manual_charge_request_in |=> charge_on;
    endproperty
    a_manual: assert property (p_manual)
        else $error("manual request ignored");
endmodule

// ===== logic/rdc_pkg.sv
/*
 * Constants and carrier types for the receive and drive configuration bank.
 * Assumes a 200 MHz core clock and a host frame decoder that delivers
 * single-byte register reads and writes on a plain strobe port.
 */
package rdc_pkg;
    localparam int unsigned RDC_CLK_MHZ = 200;
    localparam logic [5:0] RDC_OFS_SHAPING = 6'h12;
    localparam logic [5:0] RDC_OFS_GAIN    = 6'h13;
    localparam logic [5:0] RDC_OFS_MONITOR = 6'h14;
    localparam logic [5:0] RDC_OFS_SUPPLY  = 6'h16;
    localparam logic [5:0] RDC_OFS_STATUS  = 6'h1c;
    localparam logic [7:0] RDC_RST_SHAPING = 8'h00;
    localparam logic [7:0] RDC_RST_GAIN    = 8'h00;
    localparam logic [7:0] RDC_RST_MONITOR = 8'h00;
    localparam logic [7:0] RDC_RST_SUPPLY  = 8'h20;
    localparam logic [7:0] RDC_MASK_SHAPING = 8'hff;
    localparam logic [7:0] RDC_MASK_GAIN    = 8'hc7;
    localparam logic [7:0] RDC_MASK_MONITOR = 8'h1f;
    localparam logic [7:0] RDC_MASK_SUPPLY  = 8'h7f;
    localparam int unsigned RDC_BIT_OVERRIDE   = 7;
    localparam int unsigned RDC_BIT_FIRST_OFF  = 7;
    localparam int unsigned RDC_BIT_LAST_OFF   = 6;
    localparam int unsigned RDC_BIT_SPAN       = 2;
    localparam int unsigned RDC_BIT_AUTO_STOP  = 6;
    localparam int unsigned RDC_BIT_FLOAT      = 5;
    localparam int unsigned RDC_BIT_CURRENT    = 4;
    localparam int unsigned RDC_BIT_STAT_FAULT = 1;
    localparam logic [2:0] RDC_WIN_OFF = 3'h7;
    localparam logic [1:0] RDC_SCHEME_DUAL = 2'h2;
    localparam logic [1:0] RDC_SCHEME_NONE = 2'h3;
    localparam int unsigned RDC_WIN0_US = 64;
    localparam int unsigned RDC_WIN1_US = 48;
    localparam int unsigned RDC_WIN2_US = 32;
    localparam int unsigned RDC_WIN3_US = 24;
    localparam int unsigned RDC_WIN4_US = 16;
    localparam int unsigned RDC_WIN5_US = 8;
    localparam int unsigned RDC_WIN6_US = 4;
    localparam int unsigned RDC_WIN4_CYC = RDC_WIN4_US * RDC_CLK_MHZ;
    localparam int unsigned RDC_WIN5_CYC = RDC_WIN5_US * RDC_CLK_MHZ;
    localparam int unsigned RDC_WIN6_CYC = RDC_WIN6_US * RDC_CLK_MHZ;
    localparam int unsigned RDC_CNT_W = 14;

    typedef struct packed {
        logic       first_stage_off;
        logic       last_stage_off;
        logic       span_5v;
        logic [1:0] preamp_gain_select;
        logic [2:0] log_slope_trim;
        logic [3:0] log_intercept_trim;
    } rdc_analog_cfg_t;

    typedef struct packed {
        logic       charge_enable;
        logic       supply_float;
        logic       charge_current_select;
        logic [3:0] charge_voltage_select;
    } rdc_supply_cfg_t;
endpackage

// ===== verification/rdc_bank_bench.sv
/*
 * Self-checking bench: register model, config outputs, stuck-pulse
 * monitor and charge control. Assumes shortened window parameters.
 */
`timescale 1ns/1ps
module rdc_bank_bench;
    import rdc_pkg::*;
    localparam int unsigned TB_WIN0 = 40;
    localparam int unsigned TB_WIN1 = 30;
    localparam int unsigned TB_WIN2 = 20;
    localparam int unsigned TB_WIN3 = 15;
    logic            clock_in = 1'b0;
    logic            rstn_in  = 1'b0;
    logic            wr       = 1'b0;
    logic            rd       = 1'b0;
    logic [5:0]      addr     = 6'h00;
    logic [7:0]      wdata    = 8'h00;
    logic [7:0]      rdata;
    logic [2:0]      fs       = 3'h0;
    logic [3:0]      fi       = 4'h0;
    logic            burst    = 1'b0;
    logic            manual   = 1'b0;
    logic            tog_a    = 1'b0;
    logic            tog_b    = 1'b0;
    logic            lvl      = 1'b0;
    logic            pin_a;
    logic            pin_b;
    rdc_analog_cfg_t acfg;
    rdc_supply_cfg_t scfg;
    logic            fault;
    logic [5:0]      ofs [4]  = '{6'h12, 6'h13, 6'h14, 6'h16};
    logic [7:0]      msk [4]  = '{8'hff, 8'hc7, 8'h1f, 8'h7f};
    logic [7:0]      mdl [4]  = '{8'h00, 8'h00, 8'h00, 8'h20};
    logic [11:0]     mon [13] = '{12'h0c1, 12'h0d4, 12'h0e5, 12'h0e9,
                                  12'h0e2, 12'h1c0, 12'h0f0, 12'h08c,
                                  12'h001, 12'h051, 12'h101, 12'h151,
                                  12'h1a5};
    logic [10:0]     chg [7]  = '{11'h051, 11'h154, 11'h250, 11'h255,
                                  11'h250, 11'h253, 11'h250};
    logic [7:0]      b;
    logic [31:0]     r;
    int              w;
    integer          seed     = 72;
    int              bad_count  = 0;
    int              num_checks = 0;

    always #2.5 clock_in = ~clock_in;

    rdc_bank #(.WIN0_CYC(TB_WIN0), .WIN1_CYC(TB_WIN1), .WIN2_CYC(TB_WIN2),
               .WIN3_CYC(TB_WIN3)) u_dut (
        .clock_in(clock_in), .rstn_in(rstn_in),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .factory_slope_in(fs), .factory_intercept_in(fi),
        .burst_active_in(burst), .manual_charge_request_in(manual),
        .burst_pin_a_in(pin_a), .burst_pin_b_in(pin_b),
        .analog_cfg_out(acfg), .supply_cfg_out(scfg),
        .stuck_pulse_fault_out(fault));

    rdc_pin_drv u_pins (
        .clock_in(clock_in), .tog_a_in(tog_a), .tog_b_in(tog_b),
        .level_in(lvl), .pin_a_out(pin_a), .pin_b_out(pin_b));

    task automatic chk(input logic [11:0] e, input logic [11:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic chk_reg(input logic [7:0] e, input logic [7:0] g);
        chk({4'h0, e}, {4'h0, g});
    endtask

    task automatic chk_bit(input logic e, input logic g);
        chk({11'h0, e}, {11'h0, g});
    endtask

    task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
        @(negedge clock_in);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clock_in);
        wr = 1'b0;
    endtask

    task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
        @(negedge clock_in);
        addr = a;
        rd = 1'b1;
        @(negedge clock_in);
        rd = 1'b0;
        d = rdata;
    endtask

    function automatic logic [11:0] exp_analog();
        return {mdl[1][7:6], mdl[1][2], mdl[1][1:0],
                mdl[0][7] ? mdl[0][6:0] : {fs, fi}};
    endfunction

    // Window length in cycles for a window code
    function automatic int win_tb(input logic [2:0] code);
        case (code)
            3'h0:    return TB_WIN0;
            3'h1:    return TB_WIN1;
            3'h2:    return TB_WIN2;
            3'h3:    return TB_WIN3;
            3'h4:    return RDC_WIN4_US * RDC_CLK_MHZ;
            3'h5:    return RDC_WIN5_US * RDC_CLK_MHZ;
            3'h6:    return RDC_WIN6_US * RDC_CLK_MHZ;
            default: return TB_WIN0;
        endcase
    endfunction

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #80000;
        bad_count++;
        finish_test;
    end

    initial begin
        repeat (6) @(negedge clock_in);
        rstn_in = 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd_reg(ofs[i], b);
            chk_reg(mdl[i], b);
        end
        chk_bit(1'b1, scfg.supply_float);
        rd_reg(6'h15, b);
        chk_reg(8'h00, b);
        for (int n = 0; n < 8; n++) begin
            r = $random(seed);
            fs = r[2:0];
            fi = r[7:4];
            for (int i = 0; i < 4; i++) begin
                r = $random(seed);
                wr_reg(ofs[i], r[7:0]);
                mdl[i] = r[7:0] & msk[i];
            end
            for (int i = 0; i < 4; i++) begin
                rd_reg(ofs[i], b);
                chk_reg(mdl[i], b);
            end
            chk(exp_analog(), acfg);
            chk({6'h0, mdl[3][5:0]}, {6'h0, scfg[5:0]});
        end
        for (int i = 0; i < 13; i++) begin
            tog_a = mon[i][3];
            tog_b = mon[i][2];
            lvl = mon[i][1];
            rd_reg(RDC_OFS_STATUS, b);
            wr_reg(6'h14, mon[i][11:4]);
            w = win_tb(mon[i][8:6]);
            @(negedge clock_in);
            burst = 1'b1;
            repeat (w) @(negedge clock_in);
            chk_bit(1'b0, fault);
            repeat (4) @(negedge clock_in);
            chk_bit(mon[i][0], fault);
            burst = 1'b0;
            rd_reg(RDC_OFS_STATUS, b);
            chk_reg({6'h0, mon[i][0], 1'b0}, b);
        end
        for (int i = 0; i < 7; i++) begin
            wr_reg(6'h16, chg[i][10:3]);
            manual = chg[i][2];
            burst = chg[i][1];
            repeat (4) @(negedge clock_in);
            chk_bit(chg[i][0], scfg.charge_enable);
        end
        finish_test;
    end
endmodule

// ===== verification/rdc_pin_drv.sv
/*
 * Burst pin driver standing in for the host side of the burst pins.
 * Assumes the bench selects per pin a toggling or a held level.
 */
`timescale 1ns/1ps
module rdc_pin_drv (
    // Clock
    input  wire logic clock_in,
    // Pin behaviour
    input  wire logic tog_a_in,
    input  wire logic tog_b_in,
    input  wire logic level_in,
    // Burst pins
    output logic      pin_a_out,
    output logic      pin_b_out
);
    // Toggle or hold each pin
    always @(negedge clock_in) begin
        pin_a_out <= tog_a_in ? ~pin_a_out : level_in;
        pin_b_out <= tog_b_in ? ~pin_b_out : level_in;
    end
endmodule
